/* logic/sms_map.svh */
// Purpose: constants for the startup mode selector (offsets, fields, resets, timing)
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes: header only, guarded
//
// Operation
// RULE1: both images good: mode 1 hot start, mode 2 cold start; auto flag off.
// RULE2: ram bad, flash good: ram error, ignore mode, restore, auto cold start.
// RULE3: flash bad, backup select 1: retry backup, cold start, auto flag on.
// RULE4: flash bad, backup select 0: stop, auto flag off.
// RULE5: retry path: ram to flash, flash to ram, then hmi data to ram.
// RULE6: both bad: ram error, fatal, auto flag on, no transfer, stop.
// RULE7: host recovers by downloading configuration then requesting cold start.
// RULE8: default configuration hot starts at power-on and restart.
// RULE9: cold start step one copies block data from flash into ram.
// RULE10: cold start step two loads set points, pid, hmi data into ram.
// RULE11: final cold step clears memory, output zero, manual, local set point.
// RULE12: hot start keeps memory, output and mode settings as preserved.
// RULE13: never hot start when ram image is lost.
// RULE14: restart request rising edge reruns power-on start selection.
// RULE15: decide once per start; hold flags until next start.
`ifndef SMS_MAP_SVH
`define SMS_MAP_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define SMS_OFF_CTRL 12'h000
`define SMS_OFF_STAT 12'h004
`define SMS_OFF_IRQ_STAT 12'h008
`define SMS_OFF_IRQ_MASK 12'h00C

// ------------------------------------------------------------
// fields
// ------------------------------------------------------------
`define SMS_CTRL_MODE_LSB 0
`define SMS_CTRL_BACKUP_BIT 2
`define SMS_CTRL_RESTART_BIT 3
`define SMS_STAT_RAMERR_BIT 0
`define SMS_STAT_FATAL_BIT 1
`define SMS_STAT_AUTO_BIT 2
`define SMS_STAT_RUN_BIT 3
`define SMS_STAT_STOP_BIT 4
`define SMS_STAT_HOT_BIT 5
`define SMS_STAT_BUSY_BIT 6
`define SMS_IRQ_RUN_BIT 0
`define SMS_IRQ_STOP_BIT 1

// ------------------------------------------------------------
// reset values and codes
// ------------------------------------------------------------
`define SMS_MODE_COLD 2'h2
`define SMS_MODE_RST 2'h1
`define SMS_BACKUP_RST 1'b1
`define SMS_MASK_RST 2'h0

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define SMS_SETTLE_CYC 2

`endif

/* logic/sms_pkg.sv */
// Purpose: types for the startup mode selector
// Assumes: nothing
// Notes: constants live in sms_map.svh
package sms_pkg;
    typedef enum logic [3:0] {
        SMS_IDLE,
        SMS_SETTLE,
        SMS_DECIDE,
        SMS_BACKUP,
        SMS_RESTORE,
        SMS_HMI,
        SMS_INIT,
        SMS_RUN,
        SMS_STOP
    } sms_state_t;

    typedef enum logic [1:0] {
        SMS_XF_BACKUP,
        SMS_XF_RESTORE,
        SMS_XF_HMI
    } sms_xfer_t;
endpackage

/* logic/sms_sync.sv */
// Purpose: two-flop synchroniser for asynchronous pins
// Assumes: single clock clk_in
// Notes: first stage read only by the second
module sms_sync (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // data
    input wire logic d_in,
    output logic q_out
);
    logic meta_ff;
    logic sync_ff;

    // two stages
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= d_in;
            sync_ff <= meta_ff;
        end
    end

    assign q_out = sync_ff;
endmodule

/* logic/sms_top.sv */
// Purpose: start method selection and cold start transfer sequencing
// Assumes: image checks and transfer engine outside; AXI4-Lite registers
// Notes: flags held from decision until next start
`include "sms_map.svh"

module sms_top (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // image health pins (asynchronous)
    input wire logic ram_valid_in,
    input wire logic flash_valid_in,
    // transfer engine handshake
    output logic xfer_start_out,
    output logic [1:0] xfer_kind_out,
    input wire logic xfer_done_in,
    // run control
    output logic clear_op_memory_out,
    output logic force_manual_out,
    output logic run_out,
    // status pins
    output logic ram_image_error_flag_out,
    output logic board_fatal_error_flag_out,
    output logic auto_cold_start_flag_out,
    output logic irq_out,
    // axi4-lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    sms_pkg::sms_state_t state_ff, nxt_state;
    logic ram_ok, flash_ok, backup_start_select_ff, board_restart_request_ff;
    logic [1:0] start_mode_setting_ff, settle_ff, xfer_kind_ff, irq_stat_ff, irq_mask_ff;
    logic restart_prev_ff, restart_rise, ram_err_ff, fatal_ff, auto_ff, hot_ff;
    logic xfer_start_ff, xfer_wait_ff, nxt_xfer, clear_ff, manual_ff, run_ff, irq_ff;
    logic ev_run, ev_stop, awready_ff, wready_ff, aw_have_ff, w_have_ff, bvalid_ff;
    logic arready_ff, rvalid_ff, wr_go, rd_go, irq_rd_clr;
    logic [1:0] bresp_ff, rresp_ff, nxt_kind, nxt_irq;
    logic [3:0] wstrb_ff;
    logic [11:0] awaddr_ff;
    logic [31:0] wdata_ff, rdata_ff, stat_word;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    sms_sync u_sync_ram (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .d_in(ram_valid_in),
        .q_out(ram_ok)
    );

    sms_sync u_sync_flash (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .d_in(flash_valid_in),
        .q_out(flash_ok)
    );

    // ------------------------------------------------------------
    // start triggers
    // ------------------------------------------------------------
    // restart request edge from register bit
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            restart_prev_ff <= 1'b0;
        end else begin
            restart_prev_ff <= board_restart_request_ff;
        end
    end

    assign restart_rise = board_restart_request_ff & ~restart_prev_ff; // RULE14

    // settle counter lets synchronised pins fill
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            settle_ff <= 2'h0;
        end else if (state_ff == sms_pkg::SMS_SETTLE) begin
            settle_ff <= settle_ff + 2'h1;
        end else begin
            settle_ff <= 2'h0;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    // next state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            sms_pkg::SMS_IDLE: begin
                nxt_state = sms_pkg::SMS_SETTLE; // power-on start
            end
            sms_pkg::SMS_SETTLE: begin
                if (settle_ff == 2'(`SMS_SETTLE_CYC)) begin
                    nxt_state = sms_pkg::SMS_DECIDE;
                end
            end
            sms_pkg::SMS_DECIDE: begin
                if (!ram_ok && !flash_ok) begin
                    nxt_state = sms_pkg::SMS_STOP; // RULE6
                end else if (!ram_ok) begin
                    nxt_state = sms_pkg::SMS_RESTORE; // RULE2 RULE13
                end else if (!flash_ok) begin
                    nxt_state = backup_start_select_ff ? sms_pkg::SMS_BACKUP
                                                       : sms_pkg::SMS_STOP; // RULE3 RULE4
                end else if (start_mode_setting_ff == `SMS_MODE_COLD) begin
                    nxt_state = sms_pkg::SMS_RESTORE; // RULE1
                end else begin
                    nxt_state = sms_pkg::SMS_RUN; // RULE1 RULE8 RULE12
                end
            end
            // transfer states are consecutive: backup, restore, hmi, then init
            sms_pkg::SMS_BACKUP, sms_pkg::SMS_RESTORE, sms_pkg::SMS_HMI: begin
                if (xfer_wait_ff && xfer_done_in) begin
                    nxt_state = sms_pkg::sms_state_t'(state_ff + 4'h1); // RULE5 RULE9 RULE10
                end
            end
            sms_pkg::SMS_INIT: begin
                nxt_state = sms_pkg::SMS_RUN; // RULE11
            end
            sms_pkg::SMS_RUN, sms_pkg::SMS_STOP: begin
                if (restart_rise) begin
                    nxt_state = sms_pkg::SMS_SETTLE; // RULE14
                end
            end
            default: begin
                nxt_state = sms_pkg::SMS_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_ff <= sms_pkg::SMS_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // status flags set once at decision, held until next start
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ram_err_ff <= 1'b0;
            fatal_ff <= 1'b0;
            auto_ff <= 1'b0;
            hot_ff <= 1'b0;
        end else if (state_ff == sms_pkg::SMS_DECIDE) begin // RULE15
            ram_err_ff <= ~ram_ok; // RULE2 RULE6
            fatal_ff <= ~ram_ok & ~flash_ok; // RULE6
            auto_ff <= ~ram_ok | (~flash_ok & backup_start_select_ff); // RULE3 RULE4
            hot_ff <= ram_ok & flash_ok & (start_mode_setting_ff != `SMS_MODE_COLD); // RULE13
        end
    end

    // transfer requests: one pulse per transfer state, then wait for done
    assign nxt_xfer = nxt_state inside {sms_pkg::SMS_BACKUP, sms_pkg::SMS_RESTORE,
                                        sms_pkg::SMS_HMI};
    assign nxt_kind = (nxt_state == sms_pkg::SMS_BACKUP) ? 2'(sms_pkg::SMS_XF_BACKUP) : // RULE5
                      (nxt_state == sms_pkg::SMS_RESTORE) ? 2'(sms_pkg::SMS_XF_RESTORE) : // RULE9
                      2'(sms_pkg::SMS_XF_HMI); // RULE10

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            xfer_start_ff <= 1'b0;
            xfer_kind_ff <= 2'h0;
            xfer_wait_ff <= 1'b0;
        end else if (nxt_state != state_ff) begin
            xfer_start_ff <= nxt_xfer;
            xfer_wait_ff <= nxt_xfer;
            if (nxt_xfer) begin
                xfer_kind_ff <= nxt_kind;
            end
        end else begin
            xfer_start_ff <= 1'b0;
        end
    end

    // run control: init pulse on cold start, manual held, run level
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            clear_ff <= 1'b0;
            manual_ff <= 1'b0;
            run_ff <= 1'b0;
        end else begin
            clear_ff <= (nxt_state == sms_pkg::SMS_INIT); // RULE11
            if (nxt_state == sms_pkg::SMS_INIT) begin
                manual_ff <= 1'b1; // RULE11
            end else if (nxt_state == sms_pkg::SMS_SETTLE) begin
                manual_ff <= 1'b0; // RULE12
            end
            run_ff <= (nxt_state == sms_pkg::SMS_RUN);
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    assign ev_run = (nxt_state == sms_pkg::SMS_RUN) && (state_ff != sms_pkg::SMS_RUN);
    assign ev_stop = (nxt_state == sms_pkg::SMS_STOP) && (state_ff != sms_pkg::SMS_STOP);
    assign irq_rd_clr = rd_go && (s_axi_araddr == `SMS_OFF_IRQ_STAT);

    assign nxt_irq = (irq_rd_clr ? 2'h0 : irq_stat_ff) | {ev_stop, ev_run};

    // sticky status, read clears, set wins; irq follows next status ANDed with irq_mask_ff
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_stat_ff <= 2'h0;
            irq_ff <= 1'b0;
        end else begin
            irq_stat_ff <= nxt_irq;
            irq_ff <= |(nxt_irq & irq_mask_ff);
        end
    end

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    assign wr_go = aw_have_ff && w_have_ff && !bvalid_ff;
    assign rd_go = s_axi_arvalid && arready_ff;

    // capture write address and data in either order
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            aw_have_ff <= 1'b0;
            awaddr_ff <= 12'h000;
            awready_ff <= 1'b1;
            w_have_ff <= 1'b0;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            wready_ff <= 1'b1;
        end else begin
            if (s_axi_awvalid && awready_ff) begin
                aw_have_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
                awready_ff <= 1'b0;
            end else if (wr_go) begin
                aw_have_ff <= 1'b0;
            end
            if (s_axi_wvalid && wready_ff) begin
                w_have_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
                wready_ff <= 1'b0;
            end else if (wr_go) begin
                w_have_ff <= 1'b0;
            end
            if (bvalid_ff && s_axi_bready) begin
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
            end
        end
    end

    // register writes and write response
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            start_mode_setting_ff <= `SMS_MODE_RST; // RULE8
            backup_start_select_ff <= `SMS_BACKUP_RST;
            board_restart_request_ff <= 1'b0;
            irq_mask_ff <= `SMS_MASK_RST;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'h0;
        end else begin
            if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
            if (wr_go) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= 2'h0;
                case (awaddr_ff)
                    `SMS_OFF_CTRL: begin
                        if (wstrb_ff[0]) begin
                            start_mode_setting_ff <= wdata_ff[`SMS_CTRL_MODE_LSB +: 2];
                            backup_start_select_ff <= wdata_ff[`SMS_CTRL_BACKUP_BIT];
                            board_restart_request_ff <= wdata_ff[`SMS_CTRL_RESTART_BIT];
                        end
                    end
                    `SMS_OFF_IRQ_MASK: begin
                        if (wstrb_ff[0]) begin
                            irq_mask_ff <= wdata_ff[1:0];
                        end
                    end
                    `SMS_OFF_STAT, `SMS_OFF_IRQ_STAT: begin
                        bresp_ff <= 2'h0;
                    end
                    default: begin
                        bresp_ff <= 2'h2;
                    end
                endcase
            end
        end
    end

    assign stat_word = {25'h000_0000, (state_ff != sms_pkg::SMS_RUN &&
                        state_ff != sms_pkg::SMS_STOP), hot_ff,
                        (state_ff == sms_pkg::SMS_STOP), run_ff, auto_ff, fatal_ff, ram_err_ff};

    // read channel
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= 2'h0;
        end else begin
            if (rd_go) begin
                arready_ff <= 1'b0;
                rvalid_ff <= 1'b1;
                rresp_ff <= 2'h0;
                case (s_axi_araddr)
                    `SMS_OFF_CTRL: rdata_ff <= {28'h000_0000, board_restart_request_ff,
                                                backup_start_select_ff, start_mode_setting_ff};
                    `SMS_OFF_STAT: rdata_ff <= stat_word;
                    `SMS_OFF_IRQ_STAT: rdata_ff <= {30'h0000_0000, irq_stat_ff};
                    `SMS_OFF_IRQ_MASK: rdata_ff <= {30'h0000_0000, irq_mask_ff};
                    default: begin
                        rdata_ff <= 32'h0000_0000;
                        rresp_ff <= 2'h2;
                    end
                endcase
            end else if (rvalid_ff && s_axi_rready) begin
                rvalid_ff <= 1'b0;
                arready_ff <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign xfer_start_out = xfer_start_ff;
    assign xfer_kind_out = xfer_kind_ff;
    assign clear_op_memory_out = clear_ff;
    assign force_manual_out = manual_ff;
    assign run_out = run_ff;
    assign ram_image_error_flag_out = ram_err_ff;
    assign board_fatal_error_flag_out = fatal_ff;
    assign auto_cold_start_flag_out = auto_ff;
    assign irq_out = irq_ff;
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
endmodule

/* test/sms_checker.sv */
// Purpose: pin-level assertions for sms_top
// Assumes: one clock, async active-low reset
// Notes: bound to sms_top at file foot
module sms_checker (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // transfer and run pins
    input wire logic xfer_start_out,
    input wire logic [1:0] xfer_kind_out,
    input wire logic clear_op_memory_out,
    input wire logic force_manual_out,
    input wire logic run_out,
    // status flags
    input wire logic ram_image_error_flag_out,
    input wire logic board_fatal_error_flag_out,
    input wire logic auto_cold_start_flag_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic [1:0] last_ff;
    logic [2:0] flg;
    // flags as fatal, auto, ram error
    assign flg = {board_fatal_error_flag_out, auto_cold_start_flag_out,
        ram_image_error_flag_out};
    // last transfer kind of this start, 3 when none
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            last_ff <= 2'h3;
        end else if (run_out) begin
            last_ff <= 2'h3;
        end else if (xfer_start_out) begin
            last_ff <= xfer_kind_out;
        end
    end
    // clear pulse, manual level, then running
    sequence s_init;
        clear_op_memory_out ##[0:1] force_manual_out ##[1:2] run_out;
    endsequence
    AST_INIT_RUN: assert property (clear_op_memory_out |-> s_init)
        else $error("init step not followed by manual run");
    AST_FATAL_FLAGS: assert property (board_fatal_error_flag_out |-> flg == 3'h7)
        else $error("fatal flag without other flags");
    AST_FATAL_STOP: assert property (flg == 3'h7 |-> !run_out && !xfer_start_out)
        else $error("run or transfer with both images bad");
    AST_XFER_PULSE: assert property (xfer_start_out |=> !xfer_start_out)
        else $error("transfer start longer than one cycle");
    AST_HMI_ORDER: assert property (xfer_start_out && xfer_kind_out == 2'h2 |-> last_ff == 2'h1)
        else $error("hmi load not after restore");
    AST_RESTORE_ORDER: assert property (xfer_start_out && xfer_kind_out == 2'h1
        |-> last_ff == (flg == 3'h2 ? 2'h0 : 2'h3))
        else $error("restore out of order");
    AST_BACKUP_PATH: assert property (xfer_start_out && xfer_kind_out == 2'h0 |-> flg == 3'h2)
        else $error("backup outside retry path");
    AST_HOT_CLEAN: assert property ($rose(run_out) && !force_manual_out |-> flg == 3'h0)
        else $error("hot start with flags set");
    AST_AUTO_COLD: assert property ($rose(run_out) && flg[1] |-> force_manual_out)
        else $error("auto start without cold init");
    AST_FLAGS_HELD: assert property (run_out && $past(run_out) |-> $stable(flg))
        else $error("flags changed while running");
endmodule

bind sms_top sms_checker i_chk (
    .clk_in, .rst_n_in, .xfer_start_out, .xfer_kind_out, .clear_op_memory_out,
    .force_manual_out, .run_out, .ram_image_error_flag_out,
    .board_fatal_error_flag_out, .auto_cold_start_flag_out
);

/* test/sms_xfer_model.sv */
// Purpose: transfer engine beside sms_top
// Assumes: same clock, one transfer at a time
// Notes: logs kind+1 per start, answers lat_in+2 cycles after start
module sms_xfer_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // transfer handshake
    input wire logic xfer_start_in,
    input wire logic [1:0] xfer_kind_in,
    output logic xfer_done_out,
    // bench control
    input wire logic [3:0] lat_in,
    input wire logic clr_in,
    output logic [7:0] log_out
);
    logic [3:0] cnt_ff;
    logic busy_ff;
    // count down, pulse done, record order
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_ff <= 1'b0;
            cnt_ff <= 4'h0;
            xfer_done_out <= 1'b0;
            log_out <= 8'h00;
        end else begin
            xfer_done_out <= busy_ff && cnt_ff == 4'h0;
            if (clr_in) begin
                log_out <= 8'h00;
            end else if (xfer_start_in) begin
                log_out <= {log_out[5:0], xfer_kind_in + 2'h1};
            end
            if (xfer_start_in) begin
                busy_ff <= 1'b1;
                cnt_ff <= lat_in;
            end else if (busy_ff) begin
                busy_ff <= cnt_ff != 4'h0;
                cnt_ff <= cnt_ff - 4'h1;
            end
        end
    end
endmodule

/* test/startup_mode_selector_tb.sv */
// Purpose: self-checking bench for sms_top
// Assumes: host drives registers over axi4-lite
// Notes: one start scenario per image/setting case
`include "sms_map.svh"

module startup_mode_selector_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0, rst_n_in = 1'b0, ram_valid_in = 1'b1, flash_valid_in = 1'b1;
    logic clr = 1'b0, xfer_start_out, xfer_done_in, clear_op_memory_out, force_manual_out;
    logic run_out, ram_image_error_flag_out, board_fatal_error_flag_out;
    logic auto_cold_start_flag_out, irq_out, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [1:0] xfer_kind_out, s_axi_bresp, s_axi_rresp;
    logic [3:0] lat = 4'h0, s_axi_wstrb = 4'hF;
    logic [7:0] xlog;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    int err_count = 0, num_checks = 0;

    sms_top i_dut (.clk_in, .rst_n_in, .ram_valid_in, .flash_valid_in, .xfer_start_out,
        .xfer_kind_out, .xfer_done_in, .clear_op_memory_out, .force_manual_out, .run_out,
        .ram_image_error_flag_out, .board_fatal_error_flag_out, .auto_cold_start_flag_out,
        .irq_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    sms_xfer_model i_xfer (.clk_in, .rst_n_in, .xfer_start_in(xfer_start_out),
        .xfer_kind_in(xfer_kind_out), .xfer_done_out(xfer_done_in), .lat_in(lat),
        .clr_in(clr), .log_out(xlog));

    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_in);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk("bresp", 32'h0000_0000, {30'h0, s_axi_bresp});
        s_axi_bready <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_in);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk_in);
    endtask
    // one restart with given images and settings
    task automatic run_case(input logic rv, fv, input logic [1:0] m, input logic s,
        input logic [3:0] l, input logic [5:0] est, input logic [7:0] elog);
        logic [31:0] d;
        logic [1:0] r;
        rd(`SMS_OFF_IRQ_STAT, d, r);
        ram_valid_in <= rv;
        flash_valid_in <= fv;
        lat <= l;
        clr <= 1'b1;
        wr(`SMS_OFF_CTRL, {28'h0, 1'b0, s, m});
        chk("irq cleared", 32'h0000_0000, {31'h0, irq_out});
        clr <= 1'b0;
        wr(`SMS_OFF_CTRL, {28'h0, 1'b1, s, m});
        for (int n = 0; n < 40; n++) begin
            rd(`SMS_OFF_IRQ_STAT, d, r);
            if (d != 32'h0) break;
        end
        chk("irq stat", {30'h0, est[4:3]}, d);
        rd(`SMS_OFF_STAT, d, r);
        chk("stat", {26'h0, est}, d);
        chk("xfer log", {24'h0, elog}, {24'h0, xlog});
        chk("flags", {29'h0, est[2:0]}, {29'h0, auto_cold_start_flag_out,
            board_fatal_error_flag_out, ram_image_error_flag_out});
        if (est[3]) chk("manual", {31'h0, ~est[5]}, {31'h0, force_manual_out});
    endtask
    task automatic stop_test();
        if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // clock, watchdog, main sequence
    // ----------------------------------------
    initial begin
        forever #4 clk_in = ~clk_in;
    end
    initial begin
        repeat (30000) @(posedge clk_in);
        err_count++;
        stop_test();
    end
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (12) @(posedge clk_in);
        rst_n_in <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(posedge clk_in);
            if (run_out) break;
        end
        rd(`SMS_OFF_STAT, d, r);
        chk("poweron stat", 32'h0000_0028, d);
        chk("poweron log", 32'h0000_0000, {24'h0, xlog});
        rd(`SMS_OFF_CTRL, d, r);
        chk("ctrl reset", 32'h0000_0005, d);
        rd(12'h010, d, r);
        chk("unmapped resp", 32'h0000_0002, {30'h0, r});
        chk("unmapped data", 32'h0000_0000, d);
        chk("irq masked", 32'h0000_0000, {31'h0, irq_out});
        wr(`SMS_OFF_IRQ_MASK, 32'h0000_0003);
        chk("irq unmasked", 32'h0000_0001, {31'h0, irq_out});
        run_case(1'b1, 1'b1, 2'h2, 1'b1, 4'h0, 6'h08, 8'h0B);
        run_case(1'b0, 1'b1, 2'h1, 1'b1, 4'h5, 6'h0D, 8'h0B);
        run_case(1'b1, 1'b0, 2'h3, 1'b1, 4'h2, 6'h0C, 8'h1B);
        run_case(1'b1, 1'b0, 2'h2, 1'b0, 4'h0, 6'h10, 8'h00);
        run_case(1'b0, 1'b0, 2'h1, 1'b1, 4'h0, 6'h17, 8'h00);
        run_case(1'b1, 1'b1, 2'h2, 1'b1, 4'h3, 6'h08, 8'h0B);
        run_case(1'b1, 1'b1, 2'h1, 1'b1, 4'h0, 6'h28, 8'h00);
        stop_test();
    end
endmodule
